//--- rtc_params.svh
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CTRL_OFFSET 8'h00
`define TIME_OFFSET 8'h04
`define IRQ_STATUS_OFFSET 8'h08
`define IRQ_MASK_OFFSET 8'h0c
`define UNLOCK_KEY_OFFSET 8'h10

// ----------------------------------------------------------------------
// Control and time register fields
// ----------------------------------------------------------------------
`define OE_BIT 0
`define HALF_BIT 1
`define HAZARD_BIT 2
`define UNLOCK_BIT 3
`define RUNNING_BIT 6
`define OUTSEL_LO 7
`define OUTSEL_HI 8
`define SRCSEL_LO 9
`define SRCSEL_HI 10
`define ON_BIT 15
`define SEC_LO 8
`define SEC_HI 14

// ----------------------------------------------------------------------
// Field codes and reset values
// ----------------------------------------------------------------------
`define SRC_INT_RC 2'b00
`define SRC_XTAL 2'b01
`define OUT_ALARM 2'b00
`define OUT_SECOND 2'b01
`define OUT_SOURCE 2'b10
`define CTRL_RESET 32'h0000_0000
`define SEC_WRAP 7'h3b
`define UNLOCK_KEY_A 32'h0000_a5a5
`define UNLOCK_KEY_B 32'h0000_5a5a

// ----------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------
`define IRQ_SECOND 0
`define IRQ_ALARM 1
`define IRQ_BLOCKED 2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define XTAL_HZ 16'd32768
`define INT_RC_HZ 16'd32000
`define HAZARD_EDGES 16'd16
`define CLK_PERIOD_NS 25
`define RUN_TIMEOUT_NS 100000
`define RUN_TIMEOUT_CYC (`RUN_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

//--- rtc_pkg.sv
package rtc_pkg;

  typedef enum logic [1:0] {
    ULK_IDLE = 2'b00,
    ULK_GOT_A = 2'b01,
    ULK_ARMED = 2'b11
  } unlock_state_t;

  typedef struct packed {
    logic on;
    logic [1:0] srcsel;
    logic [1:0] outsel;
    logic unlock;
    logic oe;
    logic [6:0] seconds;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    unlock_state_t ulk;
    logic [31:0] rdata;
    logic [11:0] run_cnt;
    logic running;
    logic pin;
  } ctrl_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } presc_state_t;

  typedef struct packed {
    logic [1:0] stage;
    logic prev;
  } sync_state_t;

endpackage

//--- pin_sync.sv
module pin_sync (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Asynchronous pin and its synchronised view
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o
);
  import rtc_pkg::*;

  sync_state_t q;
  sync_state_t d;

  // Stage 0 feeds only stage 1; everything else looks at stage 1.
  always_comb begin
    d = q;
    d.stage = {q.stage[0], pin_i};
    d.prev = q.stage[1];
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.stage[1];
  assign rise_o = q.stage[1] & ~q.prev;
endmodule

//--- rtc_prescaler.sv
`include "rtc_params.svh"

module rtc_prescaler (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Source edges and control
  input wire logic edge_i,
  input wire logic clear_i,
  input wire logic [15:0] limit_i,
  // Second phase
  output logic half_o,
  output logic hazard_o,
  output logic second_o
);
  import rtc_pkg::*;

  presc_state_t q;
  presc_state_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (clear_i) begin
      d.cnt = 16'h0000;
    end else if (edge_i && limit_i != 16'h0000) begin
      if (q.cnt >= limit_i - 16'h0001) begin
        d.cnt = 16'h0000;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign half_o = (limit_i != 16'h0000) && (q.cnt >= (limit_i >> 1));
  // The last few source edges before the wrap are where a read may tear.
  assign hazard_o = (limit_i != 16'h0000) && (q.cnt >= limit_i - `HAZARD_EDGES);
  assign second_o = q.tick;
endmodule

//--- rtc_control_settings.sv
// Function
// - Source select 00 internal, 01 crystal.
// - Output select 10 source, 01 seconds clock.
// - Output select 00 pulses on alarm.
// - Running bit shows clock actually running.
// - Unlock bit gates time value writes.
// - Hazard bit flags possible rollover tearing.
// - Half-second bit marks second half.
// - Control bits 5 and 4 read zero.
// - Pin driven only with output enable.
// - Seconds write clears half-second bit.
// - Unlock bit set only after key sequence.
// - Control register cleared only by power-on.
//
// The implementer's own choices: the strobed register port and the address map.
`include "rtc_params.svh"

module rtc_control_settings (
  // Clock and resets
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic sys_reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Oscillator pins and alarm event
  input wire logic low_power_rc_osc_i,
  input wire logic secondary_crystal_osc_i,
  input wire logic alarm_event_i,
  // Clock output pin and interrupt
  output logic clk_out_o,
  output logic clk_out_en_o,
  output logic irq_o
);
  import rtc_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  ctrl_state_t q;
  ctrl_state_t d;
  logic rc_level;
  logic rc_rise;
  logic xtal_level;
  logic xtal_rise;
  logic src_level;
  logic src_rise;
  logic [15:0] limit;
  logic half_second_flag;
  logic rollover_read_hazard;
  logic second_tick;
  logic time_wr;
  logic time_wr_ok;
  logic ctrl_wr;
  logic presc_clear;

  // ----------------------------------------------------------------------
  // Oscillator pins and source selection
  // ----------------------------------------------------------------------
  pin_sync u_rc_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(low_power_rc_osc_i),
    .level_o(rc_level),
    .rise_o(rc_rise)
  );

  pin_sync u_xtal_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(secondary_crystal_osc_i),
    .level_o(xtal_level),
    .rise_o(xtal_rise)
  );

  // Reserved source codes select nothing, so the calendar simply stops.
  always_comb begin
    src_level = 1'b0;
    src_rise = 1'b0;
    limit = 16'h0000;
    if (q.on) begin
      unique case (q.srcsel)
        `SRC_XTAL: begin
          src_level = xtal_level;
          src_rise = xtal_rise;
          limit = `XTAL_HZ;
        end
        `SRC_INT_RC: begin
          src_level = rc_level;
          src_rise = rc_rise;
          limit = `INT_RC_HZ;
        end
        default: begin
          src_level = 1'b0;
          src_rise = 1'b0;
          limit = 16'h0000;
        end
      endcase
    end
  end

  assign ctrl_wr = reg_wr_i && hit(reg_addr_i, `CTRL_OFFSET);
  assign time_wr = reg_wr_i && hit(reg_addr_i, `TIME_OFFSET);
  assign time_wr_ok = time_wr && q.unlock;
  // A permitted seconds write restarts the prescaler, which is also how a
  // source change is expected to be finished off by software.
  assign presc_clear = time_wr_ok;

  rtc_prescaler u_presc (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .edge_i(src_rise),
    .clear_i(presc_clear),
    .limit_i(limit),
    .half_o(half_second_flag),
    .hazard_o(rollover_read_hazard),
    .second_o(second_tick)
  );

  // ----------------------------------------------------------------------
  // Register and status logic
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.rdata = 32'h0000_0000;

    // Key sequence; any other write in between starts it over.
    if (reg_wr_i && hit(reg_addr_i, `UNLOCK_KEY_OFFSET)) begin
      unique case (q.ulk)
        ULK_IDLE: d.ulk = (reg_wdata_i == `UNLOCK_KEY_A) ? ULK_GOT_A : ULK_IDLE;
        ULK_GOT_A: d.ulk = (reg_wdata_i == `UNLOCK_KEY_B) ? ULK_ARMED : ULK_IDLE;
        ULK_ARMED: d.ulk = ULK_ARMED;
        default: d.ulk = ULK_IDLE;
      endcase
    end else if (reg_wr_i && q.ulk == ULK_GOT_A) begin
      d.ulk = ULK_IDLE;
    end

    if (ctrl_wr) begin
      d.srcsel = reg_wdata_i[`SRCSEL_HI:`SRCSEL_LO];
      d.outsel = reg_wdata_i[`OUTSEL_HI:`OUTSEL_LO];
      d.oe = reg_wdata_i[`OE_BIT];
      if (q.unlock) begin
        d.on = reg_wdata_i[`ON_BIT];
      end
      if (!reg_wdata_i[`UNLOCK_BIT]) begin
        d.unlock = 1'b0;
      end else if (q.ulk == ULK_ARMED) begin
        d.unlock = 1'b1;
        d.ulk = ULK_IDLE;
      end
    end

    if (time_wr_ok) begin
      d.seconds = reg_wdata_i[`SEC_HI:`SEC_LO];
    end else if (second_tick) begin
      d.seconds = (q.seconds >= `SEC_WRAP) ? 7'h00 : q.seconds + 7'h01;
    end

    if (reg_wr_i && hit(reg_addr_i, `IRQ_MASK_OFFSET)) begin
      d.irq_mask = reg_wdata_i[2:0];
    end
    // Write one to clear; a fresh event in the same cycle stays set.
    if (reg_wr_i && hit(reg_addr_i, `IRQ_STATUS_OFFSET)) begin
      d.irq_status = q.irq_status & ~reg_wdata_i[2:0];
    end
    d.irq_status[`IRQ_SECOND] = d.irq_status[`IRQ_SECOND] | second_tick;
    d.irq_status[`IRQ_ALARM] = d.irq_status[`IRQ_ALARM] | alarm_event_i;
    d.irq_status[`IRQ_BLOCKED] = d.irq_status[`IRQ_BLOCKED] | (time_wr && !q.unlock);

    // Running means enabled and a source edge seen within the timeout.
    if (!q.on || limit == 16'h0000) begin
      d.run_cnt = 12'h000;
    end else if (src_rise) begin
      d.run_cnt = 12'(`RUN_TIMEOUT_CYC);
    end else if (q.run_cnt != 12'h000) begin
      d.run_cnt = q.run_cnt - 12'h001;
    end
    d.running = d.run_cnt != 12'h000;

    d.pin = 1'b0;
    if (q.oe) begin
      unique case (q.outsel)
        `OUT_SOURCE: d.pin = src_level;
        `OUT_SECOND: d.pin = half_second_flag;
        `OUT_ALARM: d.pin = alarm_event_i;
        default: d.pin = 1'b0;
      endcase
    end

    if (reg_rd_i) begin
      if (hit(reg_addr_i, `CTRL_OFFSET)) begin
        d.rdata[`ON_BIT] = q.on;
        d.rdata[`SRCSEL_HI:`SRCSEL_LO] = q.srcsel;
        d.rdata[`OUTSEL_HI:`OUTSEL_LO] = q.outsel;
        d.rdata[`RUNNING_BIT] = q.running;
        d.rdata[`UNLOCK_BIT] = q.unlock;
        d.rdata[`HAZARD_BIT] = rollover_read_hazard;
        d.rdata[`HALF_BIT] = half_second_flag;
        d.rdata[`OE_BIT] = q.oe;
      end else if (hit(reg_addr_i, `TIME_OFFSET)) begin
        d.rdata[`SEC_HI:`SEC_LO] = q.seconds;
      end else if (hit(reg_addr_i, `IRQ_STATUS_OFFSET)) begin
        d.rdata[2:0] = q.irq_status;
      end else if (hit(reg_addr_i, `IRQ_MASK_OFFSET)) begin
        d.rdata[2:0] = q.irq_mask;
      end
    end
  end

  // The power-on reset clears everything. A system reset drops only the key
  // sequence and the read data; the whole control word, unlock bit included,
  // keeps its settings, so software need not redo the key after a warm reset.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.srcsel <= 2'(`CTRL_RESET >> `SRCSEL_LO);
    end else if (sys_reset_i) begin
      q <= d;
      q.ulk <= ULK_IDLE;
      q.rdata <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign clk_out_o = q.pin;
  assign clk_out_en_o = q.oe;
  assign irq_o = |(q.irq_status & q.irq_mask);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_reserved_zero;
    reg_rd_i && hit(reg_addr_i, `CTRL_OFFSET) |=> reg_rdata_o[5:4] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_blocked_write;
    time_wr && !q.unlock && !second_tick |=> $stable(q.seconds);
  endproperty
  a_blocked_write: assert property (p_blocked_write) else $error("locked write landed");

  property p_unlock_seq;
    $rose(q.unlock) |-> $past(q.ulk) == ULK_ARMED;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("unlock without keys");

  property p_oe_off;
    !q.oe |=> !clk_out_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin active while disabled");

  property p_alarm_pin;
    q.oe && q.outsel == `OUT_ALARM && alarm_event_i |=> clk_out_o;
  endproperty
  a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pulse missing");

  property p_source_pin;
    q.oe && q.outsel == `OUT_SOURCE |=> clk_out_o == $past(src_level);
  endproperty
  a_source_pin: assert property (p_source_pin) else $error("source not on pin");

  property p_half_clear;
    time_wr_ok |=> !half_second_flag;
  endproperty
  a_half_clear: assert property (p_half_clear) else $error("half flag not cleared");

  property p_stopped;
    !q.on ##1 !q.on |-> !q.running;
  endproperty
  a_stopped: assert property (p_stopped) else $error("running while off");

  property p_xtal_rate;
    q.on && q.srcsel == `SRC_XTAL |-> limit == `XTAL_HZ;
  endproperty
  a_xtal_rate: assert property (p_xtal_rate) else $error("wrong crystal rate");

  property p_hazard_late;
    rollover_read_hazard |-> half_second_flag;
  endproperty
  a_hazard_late: assert property (p_hazard_late) else $error("hazard in first half");

  c_alarm_pin: cover property (q.oe && q.outsel == `OUT_ALARM && alarm_event_i ##1 clk_out_o);
  c_unlock: cover property ($rose(q.unlock));
  c_second: cover property (second_tick);
  c_irq: cover property ($rose(irq_o));
  c_warm_reset: cover property (sys_reset_i && q.unlock);
endmodule

//--- osc_source_model.sv
module osc_source_model (
  // Clock
  input wire logic ref_clk_i,
  // Oscillator run controls
  input wire logic rc_run_i,
  input wire logic xtal_run_i,
  // Oscillator pins
  output logic rc_o,
  output logic xtal_o,
  // Clock output pin watch
  input wire logic pin_i,
  output int toggles_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic pin_last;

  initial begin
    rc_o = 1'b0;
    xtal_o = 1'b0;
    pin_last = 1'b0;
    toggles_o = 0;
  end

  // A stopped oscillator freezes, so the running flag sees true silence.
  // The toggle rate is the fastest a two-stage synchroniser can follow.
  always @(posedge ref_clk_i) begin
    if (rc_run_i) begin
      rc_o <= ~rc_o;
    end
    if (xtal_run_i) begin
      xtal_o <= ~xtal_o;
    end
    if (pin_i !== pin_last) begin
      toggles_o <= toggles_o + 1;
    end
    pin_last <= pin_i;
  end
endmodule

//--- rtc_control_settings_tb.sv
`include "rtc_params.svh"

module rtc_control_settings_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------
  // Signals and table
  // --------------------
  localparam int EDGE = 2;
  localparam int TMO = 110000;

  typedef struct packed {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] m;
    logic [31:0] e;
  } row_t;

  logic clk, rst, srst, wr, rd, rc, xtal, alarm, pin, pin_en, irq, rc_run, xtal_run;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v, v2;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0, k, toggles;

  // Unmapped place, bits 5:4, refused unlock and ON, blocked time write.
  row_t rows [6] = '{
    '{`IRQ_MASK_OFFSET, 32'h0000_0007, 32'h0000_0007, 32'h0000_0007},
    '{8'h20, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000},
    '{`CTRL_OFFSET, 32'h0000_0039, 32'h0000_0039, 32'h0000_0001},
    '{`CTRL_OFFSET, 32'h0000_8580, 32'h0000_8781, 32'h0000_0580},
    '{`IRQ_MASK_OFFSET, 32'h0000_0000, 32'h0000_0007, 32'h0000_0000},
    '{`TIME_OFFSET, 32'h0000_2a00, 32'h0000_7f00, 32'h0000_0000}
  };

  rtc_control_settings DUT (
    .ref_clk_i(clk), .reset_i(rst), .sys_reset_i(srst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .low_power_rc_osc_i(rc), .secondary_crystal_osc_i(xtal),
    .alarm_event_i(alarm), .clk_out_o(pin), .clk_out_en_o(pin_en), .irq_o(irq)
  );

  osc_source_model u_osc (
    .ref_clk_i(clk), .rc_run_i(rc_run), .xtal_run_i(xtal_run),
    .rc_o(rc), .xtal_o(xtal), .pin_i(pin), .toggles_o(toggles)
  );

  // --------------------
  // Tasks
  // --------------------
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    chk(name, e & m, d & m);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_to(input int t);
    while (cyc < t) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------
  // Clock and timeout
  // --------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    rst = 1'b1; srst = 1'b0; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    alarm = 1'b0; rc_run = 1'b0; xtal_run = 1'b0;
    cycles(20);
    rst <= 1'b0;
    #1 chk("reset outputs", 32'h0, {29'h0, irq, pin, pin_en});
    chk("reset rdata", 32'h0, rdata);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      rd_chk("table row", rows[i].a, rows[i].m, rows[i].e);
    end
    rd_chk("blocked status", `IRQ_STATUS_OFFSET, 32'h7, 32'h4);
    chk("irq masked", 32'h0, irq);
    wr_reg(`IRQ_MASK_OFFSET, 32'h4);
    cycles(2);
    #1 chk("irq raised", 32'h1, irq);
    wr_reg(`IRQ_STATUS_OFFSET, 32'h4);
    cycles(2);
    #1 chk("irq cleared", 32'h0, irq);
    wr_reg(`UNLOCK_KEY_OFFSET, `UNLOCK_KEY_A);
    wr_reg(`UNLOCK_KEY_OFFSET, `UNLOCK_KEY_B);
    wr_reg(`CTRL_OFFSET, 32'h0000_0109);
    wr_reg(`CTRL_OFFSET, 32'h0000_8109);
    rd_chk("unlocked ctrl", `CTRL_OFFSET, 32'h8789, 32'h8109);
    @(posedge clk);
    rc_run <= 1'b1;
    wr_reg(`TIME_OFFSET, 32'h0);
    t0 = cyc;
    cycles(50);
    rd_chk("running", `CTRL_OFFSET, 32'h40, 32'h40);
    k = toggles;
    cycles(20);
    chk("source on pin", 32'h1, (toggles - k >= 8) && pin_en);
    // The count runs through a whole second, so this part dominates run time.
    wait_to(t0 + 15900 * EDGE);
    rd_chk("first half", `CTRL_OFFSET, 32'h6, 32'h0);
    wait_to(t0 + 16100 * EDGE);
    rd_chk("second half", `CTRL_OFFSET, 32'h6, 32'h2);
    wr_reg(`TIME_OFFSET, 32'h0000_3b00);
    t0 = cyc;
    rd_chk("half cleared", `CTRL_OFFSET, 32'h2, 32'h0);
    wait_to(t0 + 31992 * EDGE);
    rd_chk("hazard", `CTRL_OFFSET, 32'h4, 32'h4);
    rd_reg(`TIME_OFFSET, v);
    rd_reg(`TIME_OFFSET, v2);
    chk("double read", v, v2);
    wait_to(t0 + 32060 * EDGE);
    rd_chk("tick", `IRQ_STATUS_OFFSET, 32'h1, 32'h1);
    rd_chk("wrap", `TIME_OFFSET, 32'h7f00, 32'h0);
    rd_chk("after wrap", `CTRL_OFFSET, 32'h6, 32'h0);
    @(posedge clk);
    rc_run <= 1'b0;
    xtal_run <= 1'b1;
    wr_reg(`CTRL_OFFSET, 32'h0000_8101);
    t0 = cyc;
    wait_to(t0 + 4100);
    rd_chk("internal idle", `CTRL_OFFSET, 32'h40, 32'h0);
    wr_reg(`CTRL_OFFSET, 32'h0000_8301);
    cycles(20);
    rd_chk("crystal running", `CTRL_OFFSET, 32'h40, 32'h40);
    wr_reg(`CTRL_OFFSET, 32'h0000_8381);
    cycles(4);
    k = toggles;
    cycles(20);
    chk("reserved output", 32'h0, toggles - k);
    wr_reg(`CTRL_OFFSET, 32'h0000_8300);
    cycles(4);
    k = toggles;
    cycles(20);
    chk("enable off", 32'h0, {pin_en, 31'(toggles - k)});
    wr_reg(`CTRL_OFFSET, 32'h0000_8281);
    cycles(2);
    rd_reg(`CTRL_OFFSET, v);
    chk("seconds on pin", {31'h0, v[`HALF_BIT]}, pin);
    wr_reg(`CTRL_OFFSET, 32'h0000_8201);
    cycles(4);
    alarm <= 1'b1;
    @(posedge clk);
    alarm <= 1'b0;
    #1 chk("alarm pulse", 32'h1, pin);
    @(posedge clk);
    #1 chk("alarm pulse end", 32'h0, pin);
    rd_chk("alarm status", `IRQ_STATUS_OFFSET, 32'h2, 32'h2);
    wr_reg(`UNLOCK_KEY_OFFSET, `UNLOCK_KEY_A);
    wr_reg(`UNLOCK_KEY_OFFSET, `UNLOCK_KEY_B);
    wr_reg(`CTRL_OFFSET, 32'h0000_8209);
    @(posedge clk);
    srst <= 1'b1;
    cycles(2);
    srst <= 1'b0;
    rd_chk("warm reset", `CTRL_OFFSET, 32'h8789, 32'h8209);
    @(posedge clk);
    rst <= 1'b1;
    cycles(2);
    rst <= 1'b0;
    rd_chk("power reset", `CTRL_OFFSET, 32'h87b9, 32'h0);
    tally_and_finish();
  end
endmodule
